// >>> dcc_pkg.sv
/*
 * Package for the converter control block: register offsets, field positions,
 * reset values, conversion lengths, state codes and the carrier structs.
 * Assumes an 8-bit register port running on the system clock.
 */
package dcc_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] DCC_OFS_CTRL      = 8'ha4;
	localparam logic [7:0] DCC_OFS_INCTL     = 8'ha5;
	localparam logic [7:0] DCC_OFS_INT_STAT  = 8'ha6;
	localparam logic [7:0] DCC_OFS_INT_MASK  = 8'ha7;
	localparam logic [7:0] DCC_OFS_RES_LOW   = 8'hac;
	localparam logic [7:0] DCC_OFS_RES_HIGH  = 8'had;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int DCC_CTRL_DONE_BIT   = 7;
	localparam int DCC_CTRL_START_BIT  = 6;
	localparam int DCC_CTRL_DAC_BIT    = 5;
	localparam int DCC_CTRL_EN_BIT     = 4;
	localparam int DCC_CTRL_ALIGN_BIT  = 3;
	localparam int DCC_CTRL_CLK_LSB    = 0;
	localparam int DCC_IN_CONNECT_BIT  = 7;
	localparam int DCC_IN_INTERNAL_REFERENCE_SELECT_BIT     = 6;
	localparam int DCC_IN_TRIG_LSB     = 4;
	localparam int DCC_IN_DIFFERENTIAL_SELECT_BIT     = 3;
	localparam int DCC_IN_CHAN_LSB     = 0;
	localparam int DCC_INT_DONE_BIT    = 0;
	localparam int DCC_INT_OVERRUN_BIT = 1;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] DCC_CTRL_RESET  = 8'h00;
	localparam logic [7:0] DCC_INCTL_RESET = 8'h00;
	localparam logic [7:0] DCC_INT_RESET   = 8'h00;
	localparam logic [3:0] DCC_ADC_TICKS   = 4'hd;   // Thirteen conversion clocks.
	localparam logic [3:0] DCC_DAC_TICKS   = 4'hb;   // Eleven conversion clocks.
	localparam logic [5:0] DCC_LEFT_PAD    = 6'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DCC_ST_IDLE = 2'b00,
		DCC_ST_CONV = 2'b01,
		DCC_ST_SYNC = 2'b10
	} dcc_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dcc_bus_s;

	typedef struct packed {
		logic       enable;
		logic       dac_mode;
		logic       active;
		logic       input_connect;
		logic       internal_reference_select;
		logic       differential_select;
		logic [2:0] channel_select;
	} dcc_core_cfg_s;

endpackage : dcc_pkg

// >>> dcc_prescaler.sv
/*
 * Conversion clock prescaler: turns the select code into a one-cycle tick.
 * Assumes sys_clk is the undivided oscillator and rc_clk_in is a free
 * running square wave from the internal RC divider, asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module dcc_prescaler
	import dcc_pkg::*;
#(
	parameter int DIV_W = 7
) (
	input  wire logic       sys_clk,        // System clock.
	input  wire logic       sys_rst,        // Asynchronous reset, active high.
	input  wire logic [2:0] clock_select,   // Conversion clock select code.
	input  wire logic       rc_clk_in,      // RC derived clock pin.
	output logic            conv_tick       // One pulse per conversion clock.
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic [2:0]       rc_sync;
		logic             rc_lvl;
		logic             tick;
	} dcc_presc_s;

	dcc_presc_s r_q;
	dcc_presc_s r_d;
	logic [DIV_W-1:0] div_mask;

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	// A nonzero code n divides by two to the n; the mask keeps the counter's low n bits.
	always_comb begin
		r_d        = r_q;
		div_mask   = DIV_W'((8'h01 << clock_select) - 8'h01);
		r_d.cnt    = r_q.cnt + 1'b1;
		r_d.rc_sync = {r_q.rc_sync[1:0], rc_clk_in};
		// The filtered level follows the pin only once the second and third stages agree.
		if (r_q.rc_sync[1] == r_q.rc_sync[2]) begin
			r_d.rc_lvl = r_q.rc_sync[2];
		end
		if (clock_select == 3'h0) begin
			// A rising edge of the filtered level; stage one is not looked at.
			r_d.tick = r_d.rc_lvl & ~r_q.rc_lvl;
		end else begin
			r_d.tick = (r_q.cnt & div_mask) == div_mask;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign conv_tick = r_q.tick;

endmodule : dcc_prescaler

// >>> dcc_converter_ctrl.sv
/*
 * Control and status registers of the combined ADC/DAC unit, with the
 * conversion sequencer, result alignment and interrupt status.
 * Assumes an 8-bit register port on sys_clk, timer overflow pulses from logic
 * on the same clock, and an analog core that presents its result by the end
 * of the conversion.
 */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module dcc_converter_ctrl
	import dcc_pkg::*;
#(
	parameter int RES_W = 10
) (
	input  wire logic                   sys_clk,     // System clock, 250 MHz.
	input  wire logic                   sys_rst,     // Asynchronous reset, active high.
	input  wire dcc_pkg::dcc_bus_s      bus,         // Register port request.
	output logic [7:0]                  rdata,       // Read data, one cycle after read.
	input  wire logic [2:0]             timer_ovf,   // Timer 0..2 overflow pulses.
	input  wire logic                   isr_ack,     // Pulse when CPU vectors to the ISR.
	input  wire logic                   rc_clk_in,   // RC derived clock pin.
	input  wire logic [RES_W-1:0]       core_result, // ADC result from the core.
	output logic                        conv_tick,   // Conversion clock tick to the core.
	output dcc_pkg::dcc_core_cfg_s      core_cfg,    // Configuration to the core.
	output logic [RES_W-1:0]            dac_value,   // Buffered DAC value.
	output logic                        done_irq,    // Conversion complete flag.
	output logic                        irq          // Masked interrupt, level.
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		dcc_state_e      state;
		logic [7:0]      ctrl;
		logic [7:0]      inctl;
		logic [7:0]      res_low;
		logic [7:0]      res_high;
		logic [7:0]      int_stat;
		logic [7:0]      int_mask;
		logic [3:0]      ticks;
		logic            dac_run;
		logic [RES_W-1:0] dac_buf;
		logic [7:0]      rdata;
		logic            irq;
		dcc_core_cfg_s   cfg;
	} dcc_ctrl_s;

	dcc_ctrl_s r_q;
	dcc_ctrl_s r_d;

	logic       wr_ctrl;
	logic       wr_inctl;
	logic       sw_start;
	logic       hw_start;
	logic       start;
	logic       finish;
	logic       enabled;
	logic [1:0] trig;
	logic [3:0] length;
	logic [7:0] rd_val;
	logic       prescaler_tick;

	// ------------------------------------------------------------
	// Conversion clock
	// ------------------------------------------------------------
	dcc_prescaler #(
		.DIV_W (7)
	) u_prescaler (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.clock_select (r_q.ctrl[DCC_CTRL_CLK_LSB +: 3]),
		.rc_clk_in    (rc_clk_in),
		.conv_tick    (prescaler_tick)
	);

	// ------------------------------------------------------------
	// Start decode
	// ------------------------------------------------------------
	// A write of zero to start/busy is simply not a start request, so a running
	// conversion is left alone; a software one in timer mode is ignored too.
	always_comb begin
		wr_ctrl  = bus.wr && (bus.addr == DCC_OFS_CTRL);
		wr_inctl = bus.wr && (bus.addr == DCC_OFS_INCTL);
		enabled  = r_q.ctrl[DCC_CTRL_EN_BIT];
		trig     = r_q.inctl[DCC_IN_TRIG_LSB +: 2];
		sw_start = wr_ctrl && bus.wdata[DCC_CTRL_START_BIT]
			&& bus.wdata[DCC_CTRL_EN_BIT] && (trig == 2'b00);
		hw_start = enabled && (trig != 2'b00) && timer_ovf[trig - 2'd1];
		start    = (sw_start || hw_start) && (r_q.state == DCC_ST_IDLE);
		length   = r_q.ctrl[DCC_CTRL_DAC_BIT] ? DCC_DAC_TICKS : DCC_ADC_TICKS;
		finish   = (r_q.state == DCC_ST_CONV) && prescaler_tick
			&& (r_q.ticks == length - 4'h1);
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		if (bus.addr == DCC_OFS_CTRL) begin
			rd_val = r_q.ctrl;
		end else if (bus.addr == DCC_OFS_INCTL) begin
			rd_val = r_q.inctl;
		end else if (bus.addr == DCC_OFS_INT_STAT) begin
			rd_val = r_q.int_stat;
		end else if (bus.addr == DCC_OFS_INT_MASK) begin
			rd_val = r_q.int_mask;
		end else if (bus.addr == DCC_OFS_RES_LOW) begin
			rd_val = r_q.res_low;
		end else if (bus.addr == DCC_OFS_RES_HIGH) begin
			rd_val = r_q.res_high;
		end else begin
			rd_val = 8'h00;    // Unmapped addresses read as zero.
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		r_d = r_q;

		// Software writes. Bits 7 and 6 of control are owned by hardware.
		if (wr_ctrl) begin
			r_d.ctrl[5:0] = bus.wdata[5:0];
		end
		if (wr_inctl) begin
			r_d.inctl = bus.wdata;
		end
		if (bus.wr && (bus.addr == DCC_OFS_INT_MASK)) begin
			r_d.int_mask = bus.wdata;
		end
		if (bus.wr && (bus.addr == DCC_OFS_INT_STAT)) begin
			r_d.int_stat = r_q.int_stat & ~bus.wdata;
		end
		// Result pair is written by software only as DAC input.
		if (bus.wr && (bus.addr == DCC_OFS_RES_LOW) && r_q.ctrl[DCC_CTRL_DAC_BIT]) begin
			r_d.res_low = bus.wdata;
		end
		if (bus.wr && (bus.addr == DCC_OFS_RES_HIGH) && r_q.ctrl[DCC_CTRL_DAC_BIT]) begin
			r_d.res_high = bus.wdata;
		end

		// Done flag clears on the vector; a completion in the same cycle wins.
		if (isr_ack) begin
			r_d.ctrl[DCC_CTRL_DONE_BIT] = 1'b0;
		end

		// Sequencer.
		case (r_q.state)
			DCC_ST_IDLE: begin
				r_d.ctrl[DCC_CTRL_START_BIT] = 1'b0;
				if (start) begin
					r_d.state = DCC_ST_CONV;
					r_d.ticks = 4'h0;
					r_d.ctrl[DCC_CTRL_START_BIT] = 1'b1;
					r_d.dac_run = r_q.ctrl[DCC_CTRL_DAC_BIT];
					// The DAC value is sampled once at the start and held.
					r_d.dac_buf = RES_W'({r_q.res_high[1:0], r_q.res_low});
				end
			end
			DCC_ST_CONV: begin
				if (prescaler_tick) begin
					r_d.ticks = r_q.ticks + 4'h1;
				end
				if (finish) begin
					r_d.state = DCC_ST_SYNC;
				end
			end
			DCC_ST_SYNC: begin
				// One system cycle to hand the flag over; busy drops with it.
				r_d.state = DCC_ST_IDLE;
				r_d.ctrl[DCC_CTRL_START_BIT] = 1'b0;
				r_d.ctrl[DCC_CTRL_DONE_BIT]  = 1'b1;
				r_d.int_stat[DCC_INT_DONE_BIT] = 1'b1;
				if (!r_q.dac_run) begin
					if (r_q.ctrl[DCC_CTRL_ALIGN_BIT]) begin
						r_d.res_high = core_result[RES_W-1:2];
						r_d.res_low  = {core_result[1:0], DCC_LEFT_PAD};
					end else begin
						r_d.res_low  = core_result[7:0];
						r_d.res_high = {{6{core_result[RES_W-1]}},
							core_result[RES_W-1:8]};
					end
				end
			end
			default: begin
				r_d.state = DCC_ST_IDLE;
			end
		endcase

		// A timer overflow while busy is dropped; report it as an overrun.
		if (hw_start && (r_q.state != DCC_ST_IDLE)) begin
			r_d.int_stat[DCC_INT_OVERRUN_BIT] = 1'b1;
		end

		// Disabling stops the sequencer and clears busy at once; no conversion runs while off.
		if (!r_d.ctrl[DCC_CTRL_EN_BIT]) begin
			r_d.state = DCC_ST_IDLE;
			r_d.ctrl[DCC_CTRL_START_BIT] = 1'b0;
		end

		r_d.rdata = bus.rd ? rd_val : 8'h00;
		r_d.irq   = |(r_d.int_stat & r_d.int_mask);

		r_d.cfg.enable                    = r_d.ctrl[DCC_CTRL_EN_BIT];
		r_d.cfg.dac_mode                  = r_d.ctrl[DCC_CTRL_DAC_BIT];
		r_d.cfg.active                    = (r_d.state == DCC_ST_CONV);
		r_d.cfg.input_connect             = r_d.inctl[DCC_IN_CONNECT_BIT];
		r_d.cfg.internal_reference_select = r_d.inctl[DCC_IN_INTERNAL_REFERENCE_SELECT_BIT];
		r_d.cfg.differential_select       = r_d.inctl[DCC_IN_DIFFERENTIAL_SELECT_BIT];
		r_d.cfg.channel_select            = r_d.inctl[DCC_IN_CHAN_LSB +: 3];
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_q          <= '0;
			r_q.state    <= DCC_ST_IDLE;
			r_q.ctrl     <= DCC_CTRL_RESET;
			r_q.inctl    <= DCC_INCTL_RESET;
			r_q.int_stat <= DCC_INT_RESET;
			r_q.int_mask <= DCC_INT_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata     = r_q.rdata;
	assign conv_tick = prescaler_tick;
	assign core_cfg  = r_q.cfg;
	assign dac_value = r_q.dac_buf;
	assign done_irq  = r_q.ctrl[DCC_CTRL_DONE_BIT];
	assign irq       = r_q.irq;

endmodule : dcc_converter_ctrl

// >>> dcc_core_model.sv
/*
 * Model of the far side: analog core result, free running RC clock and
 * timer overflow pulses. Assumes the bench requests overflows through fire.
 */
`timescale 1ns/1ps
module dcc_core_model #(
	parameter logic [9:0] RES = 10'h2a5
) (
	input  wire logic       sys_clk,     // System clock.
	input  wire logic [2:0] fire,        // Bench request for overflows.
	output logic            rc_clk_in,   // Free running RC clock.
	output logic [9:0]      core_result, // Conversion result.
	output logic [2:0]      timer_ovf    // Timer overflow pulses.
);
	// The RC source runs free at 2 MHz; the offset keeps its edges off sys_clk.
	initial begin
		rc_clk_in = 1'b0;
		#1.3;
		forever #250 rc_clk_in = ~rc_clk_in;
	end

	// The core settles its word well before a conversion ends.
	assign core_result = RES;

	// Overflows are one-cycle pulses on the system clock.
	initial timer_ovf = 3'b000;
	always @(posedge sys_clk) timer_ovf <= fire;
endmodule : dcc_core_model

// >>> dcc_converter_ctrl_assertions.sv
/*
 * Checker for the converter control block, bound to its ports.
 * Assumes the single system clock domain and its asynchronous reset.
 */
`timescale 1ns/1ps
module dcc_converter_ctrl_assertions
	import dcc_pkg::*;
(
	input wire logic                  sys_clk,   // System clock.
	input wire logic                  sys_rst,   // Reset, active high.
	input wire dcc_pkg::dcc_bus_s     bus,       // Register port request.
	input wire logic [7:0]            rdata,     // Read data.
	input wire logic [2:0]            timer_ovf, // Timer overflows.
	input wire logic                  isr_ack,   // Vector acknowledge.
	input wire dcc_pkg::dcc_core_cfg_s core_cfg, // Core configuration.
	input wire logic                  done_irq,  // Done flag.
	input wire logic                  irq        // Masked interrupt.
);
	logic [1:0] trig_q;

	// The trigger field is not a port, so it is shadowed from bus writes.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) trig_q <= 2'b00;
		else if (bus.wr && bus.addr == DCC_OFS_INCTL) trig_q <= bus.wdata[5:4];
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data not zero outside read answer");
	a_done_clear: assert property ($fell(done_irq) |-> $past(isr_ack) || $past(isr_ack, 2))
		else $error("done flag cleared without vector");
	a_done_ends_busy: assert property ($rose(done_irq) |-> $past(core_cfg.active, 2) && !core_cfg.active)
		else $error("done flag without finishing conversion");
	a_off_no_conv: assert property (!core_cfg.enable |-> !core_cfg.active)
		else $error("activity while disabled");
	a_busy_holds: assert property ($rose(core_cfg.active) |-> core_cfg.active [*8])
		else $error("busy dropped early");
	a_ctrl_fields: assert property (bus.wr && bus.addr == DCC_OFS_CTRL |=>
		core_cfg.dac_mode == $past(bus.wdata[5]) && core_cfg.enable == $past(bus.wdata[4]))
		else $error("mode or enable not taken from write");
	a_input_fields: assert property (bus.wr && bus.addr == DCC_OFS_INCTL |=>
		{core_cfg.input_connect, core_cfg.internal_reference_select, core_cfg.differential_select,
		core_cfg.channel_select} == {$past(bus.wdata[7:6]), $past(bus.wdata[3:0])})
		else $error("input control fields misplaced");
	a_sw_start: assert property (bus.wr && bus.addr == DCC_OFS_CTRL && bus.wdata[6] && bus.wdata[4]
		&& trig_q == 2'b00 && !core_cfg.active |=> core_cfg.active)
		else $error("software start not taken");
	a_timer_start: assert property (core_cfg.enable && !core_cfg.active && trig_q != 2'b00
		&& timer_ovf[trig_q - 2'd1] |=> core_cfg.active)
		else $error("timer overflow did not start conversion");

	c_done: cover property ($rose(done_irq));
	c_irq: cover property ($rose(irq));
	c_timer: cover property (trig_q != 2'b00 && $rose(core_cfg.active));
endmodule : dcc_converter_ctrl_assertions

bind dcc_converter_ctrl dcc_converter_ctrl_assertions i_chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .timer_ovf(timer_ovf),
	.isr_ack(isr_ack), .core_cfg(core_cfg), .done_irq(done_irq), .irq(irq));

// >>> dual_converter_control_regs_test.sv
/*
 * Testbench: register table, clock select periods, conversions in both
 * alignments and by timer, interrupt path. Assumes the core model beside it.
 */
`timescale 1ns/1ps
module dual_converter_control_regs_test;
	import dcc_pkg::*;
	localparam logic [9:0] RES = 10'h2a5;
	typedef struct {logic [7:0] a, d, e;} dcc_row_s;
	typedef struct {logic [2:0] c; logic [7:0] p;} dcc_tick_s;
	logic          sys_clk, sys_rst, isr_ack, rc_clk_in, conv_tick, done_irq, irq;
	dcc_bus_s      bus;
	dcc_core_cfg_s core_cfg;
	logic [7:0]    rdata;
	logic [2:0]    timer_ovf, fire;
	logic [9:0]    core_result, dac_value;
	int            err_total, n_checks, cyc, t0, g;
	// Control bits 7 and 6 never store; a start without enable stays idle.
	dcc_row_s rows [9] = '{'{8'ha5, 8'hc8, 8'hc8}, '{8'ha5, 8'h37, 8'h37},
		'{8'ha5, 8'h00, 8'h00}, '{8'ha4, 8'hef, 8'h2f}, '{8'ha4, 8'h40, 8'h00},
		'{8'ha4, 8'h20, 8'h20}, '{8'ha4, 8'h00, 8'h00}, '{8'ha7, 8'h03, 8'h03},
		'{8'h50, 8'hff, 8'h00}};
	// Code zero follows the 500 ns RC clock, others divide sys_clk.
	dcc_tick_s ticks [8] = '{'{3'd0, 8'd125}, '{3'd1, 8'd2}, '{3'd2, 8'd4}, '{3'd3, 8'd8},
		'{3'd4, 8'd16}, '{3'd5, 8'd32}, '{3'd6, 8'd64}, '{3'd7, 8'd128}};

	dcc_converter_ctrl #(.RES_W(10)) i_dcc_converter_ctrl (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .bus(bus), .rdata(rdata), .timer_ovf(timer_ovf), .isr_ack(isr_ack),
		.rc_clk_in(rc_clk_in), .core_result(core_result), .conv_tick(conv_tick),
		.core_cfg(core_cfg), .dac_value(dac_value), .done_irq(done_irq), .irq(irq));
	dcc_core_model #(.RES(RES)) i_dcc_core_model (.sys_clk(sys_clk), .fire(fire),
		.rc_clk_in(rc_clk_in), .core_result(core_result), .timer_ovf(timer_ovf));

	// Clock at 4 ns.
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out

	// The ceiling is far above the few thousand cycles the tests need.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk) bus.wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk) bus.rd <= 1'b0;
		#1 chk8(rdata, e);
	endtask : rd

	task automatic tk();
		@(posedge sys_clk);
		#1;
	endtask : tk

	task automatic gap(output int n);
		n = 0;
		do tk(); while (conv_tick !== 1'b1);
		do begin tk(); n++; end while (conv_tick !== 1'b1 && n < 300);
	endtask : gap

	// One conversion; a cleared bit 6 in c means a timer start.
	task automatic run(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
		wr(8'ha4, c);
		if (!c[6]) begin
			@(posedge sys_clk) fire <= 3'b001;
			@(posedge sys_clk) fire <= 3'b000;
		end
		t0 = cyc;
		rd(8'ha4, {2'b01, c[5:0]});
		wr(8'ha4, {2'b00, c[5:0]});
		rd(8'ha4, {2'b01, c[5:0]});
		while (done_irq !== 1'b1) tk();
		// Thirteen ticks of two cycles plus the sync slack.
		chk1((cyc - t0) inside {[25:30]}, 1'b1);
		rd(8'ha4, {2'b10, c[5:0]});
		chk1(irq, 1'b1);
		rd(8'hac, lo);
		rd(8'had, hi);
		wr(8'ha6, 8'h01);
		tk();
		chk1(irq, 1'b0);
		@(posedge sys_clk) isr_ack <= 1'b1;
		@(posedge sys_clk) isr_ack <= 1'b0;
		tk();
		chk1(done_irq, 1'b0);
		rd(8'ha4, {2'b00, c[5:0]});
		$display("test conversion %h done", c);
	endtask : run

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		bus = '0;
		isr_ack = 1'b0;
		fire = 3'b000;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(8'ha4, 8'h00);
		rd(8'ha5, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		$display("test table done");
		foreach (ticks[i]) begin
			wr(8'ha4, {5'h02, ticks[i].c});
			gap(g);
			gap(g);
			chk8(g[7:0], ticks[i].p);
		end
		$display("test clock select done");
		run(8'h51, RES[7:0], {{6{RES[9]}}, RES[9:8]});
		run(8'h59, {RES[1:0], 6'h00}, RES[9:2]);
		wr(8'ha5, 8'h10);
		run(8'h11, RES[7:0], {{6{RES[9]}}, RES[9:8]});
		// DAC mode: the result pair is the value to output, buffered at the start.
		wr(8'ha5, 8'h00);
		wr(8'ha4, 8'h31);
		wr(8'hac, 8'h5a);
		wr(8'had, 8'h02);
		wr(8'ha4, 8'h71);
		while (done_irq !== 1'b1) tk();
		chk8(dac_value[7:0], 8'h5a);
		chk8({6'h00, dac_value[9:8]}, 8'h02);
		$display("test dac conversion done");
		close_out();
	end
endmodule : dual_converter_control_regs_test
